/* File: hw/fcr_pkg.sv */
package fcr_pkg;

   // ****************************************
   // Serial command opcodes
   // ****************************************
   localparam logic [7:0] OP_WR_ENABLE = 8'h06;
   localparam logic [7:0] OP_WR_DISABLE = 8'h04;
   localparam logic [7:0] OP_RD_PERSIST = 8'hB5;
   localparam logic [7:0] OP_WR_PERSIST = 8'hB1;
   localparam logic [7:0] OP_RD_RUNTIME = 8'h85;
   localparam logic [7:0] OP_WR_RUNTIME = 8'h81;

   // Frame lengths in serial clock edges
   localparam logic [5:0] LEN_CMD = 6'h08;
   localparam logic [5:0] LEN_RUNTIME = 6'h10;
   localparam logic [5:0] LEN_PERSIST = 6'h18;

   // ****************************************
   // Persistent setup fields
   // ****************************************
   localparam int NV_DUMMY_LSB = 12;
   localparam int NV_XIP_LSB = 9;
   localparam int NV_DRV_LSB = 6;
   localparam int NV_DTR_BIT = 5;
   localparam int NV_HOLD_BIT = 4;
   localparam int NV_QUAD_BIT = 3;
   localparam int NV_DUAL_BIT = 2;
   localparam int NV_SEG_BIT = 1;
   localparam int NV_ADDR_BIT = 0;
   localparam logic [15:0] NV_RESET = 16'hFFFF;

   // ****************************************
   // Runtime setup fields
   // ****************************************
   localparam int V_DUMMY_LSB = 4;
   localparam int V_XIP_BIT = 3;
   localparam int V_RSVD_BIT = 2;
   localparam int V_WRAP_LSB = 0;
   localparam logic [7:0] V_RESET = 8'hFB;

   // ****************************************
   // Field codes
   // ****************************************
   localparam logic [3:0] DUMMY_DEFAULT_CODE = 4'hF;
   localparam logic [3:0] DUMMY_ALIAS_CODE = 4'h0;
   localparam logic [2:0] XIP_OFF = 3'h7;
   localparam logic [2:0] XIP_RSVD_A = 3'h5;
   localparam logic [2:0] XIP_RSVD_B = 3'h6;
   localparam logic [2:0] XIP_FAST = 3'h0;
   localparam logic [1:0] WRAP_16 = 2'h0;
   localparam logic [1:0] WRAP_32 = 2'h1;
   localparam logic [1:0] WRAP_64 = 2'h2;
   localparam logic [1:0] WRAP_NONE = 2'h3;
   localparam logic [31:0] MASK_16 = 32'h0000_000F;
   localparam logic [31:0] MASK_32 = 32'h0000_001F;
   localparam logic [31:0] MASK_64 = 32'h0000_003F;
   localparam int FLAG_PROT_BIT = 1;

   typedef enum logic [1:0] {
      FCR_PROTO_EXT,
      FCR_PROTO_DUAL,
      FCR_PROTO_QUAD
   } fcr_proto_t;

   typedef struct packed {
      logic [3:0] dummy_code;
      logic xip_en;
      logic [2:0] xip_mode;
      logic [2:0] drv;
      logic dtr_en;
      logic hold_rst_en;
      fcr_proto_t proto;
      logic seg_high;
      logic four_byte;
      logic [1:0] wrap;
   } fcr_cfg_t;

endpackage : fcr_pkg

/* File: hw/fcr_config_regs.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Behaviour follows hidden working setup only
// - Power-on or reset copies persistent into working
// - Finished runtime write loads working setup at once
// - Reserved persistent code: discard, flag error, drop enable
// - Persistent 15:12 dummy count, 0 equals default
// - Persistent 11:9 picks power-on execute-in-place mode
// - Persistent bit 5 low enables double rate
// - Persistent bit 4 enables pause/restart on line three
// - Persistent bit 3 low enables four-line entry
// - Persistent bit 2 low enables two-line entry
// - Four-line wins when bits 2 and 3 low
// - Persistent bit 1 picks power-on segment
// - Persistent bit 0 picks 3 or 4 address bytes
// - Runtime write download replaces only dummy, execute-in-place and wrap fields
// - Runtime 7:4 dummy count, same coding
// - Runtime bit 3 low enables execute-in-place; bit 2 zero
// - Runtime wrap 00/01/10 gives 16/32/64 byte blocks
// - Wrap climbs to block end, restarts at block start
// - Wrap 11 runs sequentially through whole array
module fcr_config_regs #(
   parameter logic [3:0] DUMMY_DEFAULT = 4'h8
) (
   // System side
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic por,
   // Serial link
   input wire logic link_sclk,
   input wire logic link_cs_n,
   input wire logic link_mosi,
   output logic link_miso,
   output logic link_miso_oe,
   // Working setup and status
   output fcr_pkg::fcr_cfg_t cfg,
   output logic [3:0] dummy_cycles,
   output logic wr_enable_latch,
   output logic prot_err_set,
   // Read address sequencer
   input wire logic rd_load,
   input wire logic [31:0] rd_load_addr,
   input wire logic rd_step,
   output logic [31:0] rd_addr
);

   // Codes 0 and 15 already stand for the default, so it must be a real count
   if (DUMMY_DEFAULT == 4'h0 || DUMMY_DEFAULT == 4'hF) begin : g_bad_dummy_default
      $error("DUMMY_DEFAULT must be 1 to 14");
   end

   // ****************************************
   // Decode helpers
   // ****************************************
   function automatic fcr_pkg::fcr_cfg_t from_persist(input logic [15:0] nv);
      fcr_pkg::fcr_cfg_t c;
      c.dummy_code = nv[fcr_pkg::NV_DUMMY_LSB +: 4];
      c.xip_mode = nv[fcr_pkg::NV_XIP_LSB +: 3];
      c.xip_en = (c.xip_mode != fcr_pkg::XIP_OFF);
      c.drv = nv[fcr_pkg::NV_DRV_LSB +: 3];
      c.dtr_en = ~nv[fcr_pkg::NV_DTR_BIT];
      c.hold_rst_en = nv[fcr_pkg::NV_HOLD_BIT];
      if (!nv[fcr_pkg::NV_QUAD_BIT]) begin
         c.proto = fcr_pkg::FCR_PROTO_QUAD;
      end else if (!nv[fcr_pkg::NV_DUAL_BIT]) begin
         c.proto = fcr_pkg::FCR_PROTO_DUAL;
      end else begin
         c.proto = fcr_pkg::FCR_PROTO_EXT;
      end
      c.seg_high = ~nv[fcr_pkg::NV_SEG_BIT];
      c.four_byte = ~nv[fcr_pkg::NV_ADDR_BIT];
      c.wrap = fcr_pkg::WRAP_NONE;
      return c;
   endfunction : from_persist

   function automatic fcr_pkg::fcr_cfg_t apply_runtime(input fcr_pkg::fcr_cfg_t cin,
                                                       input logic [7:0] v);
      fcr_pkg::fcr_cfg_t c;
      c = cin;
      c.dummy_code = v[fcr_pkg::V_DUMMY_LSB +: 4];
      c.xip_en = ~v[fcr_pkg::V_XIP_BIT];
      // Enabling with no power-on mode falls back to plain fast read
      if (c.xip_en && c.xip_mode == fcr_pkg::XIP_OFF) begin
         c.xip_mode = fcr_pkg::XIP_FAST;
      end
      c.wrap = v[fcr_pkg::V_WRAP_LSB +: 2];
      return c;
   endfunction : apply_runtime

   function automatic logic [3:0] dummy_count(input logic [3:0] code);
      if (code == fcr_pkg::DUMMY_DEFAULT_CODE || code == fcr_pkg::DUMMY_ALIAS_CODE) begin
         return DUMMY_DEFAULT;
      end
      return code;
   endfunction : dummy_count

   function automatic logic persist_reserved(input logic [15:0] nv);
      logic bad;
      bad = 1'b0;
      case (nv[fcr_pkg::NV_XIP_LSB +: 3])
         fcr_pkg::XIP_RSVD_A: bad = 1'b1;
         fcr_pkg::XIP_RSVD_B: bad = 1'b1;
         default: bad = 1'b0;
      endcase
      // Even driver codes are all reserved
      if (!nv[fcr_pkg::NV_DRV_LSB]) begin
         bad = 1'b1;
      end
      return bad;
   endfunction : persist_reserved

   // ****************************************
   // Stored registers (system domain)
   // ****************************************
   logic [15:0] persistent_setup_reg;
   logic [7:0] runtime_setup_reg;

   // ****************************************
   // Link domain: shifter on the serial clock
   // ****************************************
   logic [5:0] edge_cnt_reg;
   logic [6:0] shift_reg;
   logic [7:0] op_reg;
   logic [15:0] wdata_reg;
   logic [5:0] len_reg;
   logic [15:0] rd_seq;

   // Counter restarts with every frame; only the frame select clears it
   always_ff @(posedge link_sclk or posedge link_cs_n) begin
      if (link_cs_n) begin
         edge_cnt_reg <= 6'h00;
      end else if (edge_cnt_reg != 6'h3F) begin
         edge_cnt_reg <= edge_cnt_reg + 6'h01;
      end
   end

   // Frame contents hold after the frame so the system side can take them
   always_ff @(posedge link_sclk) begin
      shift_reg <= {shift_reg[5:0], link_mosi};
      if (edge_cnt_reg == 6'h07) begin
         op_reg <= {shift_reg, link_mosi};
      end
      if (edge_cnt_reg >= fcr_pkg::LEN_CMD && edge_cnt_reg < fcr_pkg::LEN_PERSIST) begin
         wdata_reg <= {wdata_reg[14:0], link_mosi};
      end
      if (edge_cnt_reg != 6'h3F) begin
         len_reg <= edge_cnt_reg + 6'h01;
      end
   end

   // Stored values only change between frames, so they are stable here
   // Index 7 leaves first, so the low byte goes out before the high byte
   always_comb begin
      case (op_reg)
         fcr_pkg::OP_RD_PERSIST: begin
            rd_seq = persistent_setup_reg;
         end
         fcr_pkg::OP_RD_RUNTIME: begin
            rd_seq = {runtime_setup_reg, runtime_setup_reg};
         end
         default: begin
            rd_seq = 16'h0000;
         end
      endcase
   end

   always_ff @(negedge link_sclk or posedge link_cs_n) begin
      if (link_cs_n) begin
         link_miso <= 1'b0;
         link_miso_oe <= 1'b0;
      end else if (edge_cnt_reg >= fcr_pkg::LEN_CMD &&
                   (op_reg == fcr_pkg::OP_RD_PERSIST || op_reg == fcr_pkg::OP_RD_RUNTIME)) begin
         link_miso <= rd_seq[4'hF - edge_cnt_reg[3:0]];
         link_miso_oe <= 1'b1;
      end
   end

   // ****************************************
   // Frame end detection (system domain)
   // ****************************************
   logic cs_s1_reg;
   logic cs_s2_reg;
   logic cs_s3_reg;
   logic frame_end;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         cs_s3_reg <= 1'b1;
      end else begin
         cs_s1_reg <= link_cs_n;
         cs_s2_reg <= cs_s1_reg;
         cs_s3_reg <= cs_s2_reg;
      end
   end

   // Link clock is stopped once select has risen; frame words are quiet
   assign frame_end = cs_s2_reg && !cs_s3_reg;

   logic wr_persist;
   logic wr_runtime;
   logic set_latch;
   logic clr_latch;
   logic persist_bad;
   logic [15:0] persist_new;
   logic [7:0] runtime_new;

   // A runtime frame shifts in one byte only, so it ends at the low end
   assign runtime_new = wdata_reg[7:0];
   assign persist_new = {wdata_reg[7:0], wdata_reg[15:8]};
   assign persist_bad = persist_reserved(persist_new);

   // ****************************************
   // Command decode at frame end
   // ****************************************
   // A frame with the wrong edge count is dropped without a trace
   always_comb begin
      wr_persist = 1'b0;
      wr_runtime = 1'b0;
      set_latch = 1'b0;
      clr_latch = 1'b0;
      if (frame_end) begin
         case (op_reg)
            fcr_pkg::OP_WR_ENABLE: begin
               set_latch = (len_reg == fcr_pkg::LEN_CMD);
            end
            fcr_pkg::OP_WR_DISABLE: begin
               clr_latch = (len_reg == fcr_pkg::LEN_CMD);
            end
            fcr_pkg::OP_WR_PERSIST: begin
               wr_persist = wr_enable_latch && (len_reg == fcr_pkg::LEN_PERSIST);
            end
            fcr_pkg::OP_WR_RUNTIME: begin
               wr_runtime = wr_enable_latch && (len_reg == fcr_pkg::LEN_RUNTIME);
            end
            default: begin
               // Reads and unknown codes leave the stored state alone
               wr_persist = 1'b0;
            end
         endcase
      end
   end

   // ****************************************
   // Write enable latch and error pulse
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (rst || por) begin
         wr_enable_latch <= 1'b0;
      end else if (wr_persist) begin
         wr_enable_latch <= 1'b0;
      end else if (set_latch) begin
         wr_enable_latch <= 1'b1;
      end else if (clr_latch) begin
         wr_enable_latch <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || por) begin
         prot_err_set <= 1'b0;
      end else begin
         prot_err_set <= wr_persist && persist_bad;
      end
   end

   // ****************************************
   // Persistent and runtime setup
   // ****************************************
   // Persistent contents survive rst; only por models a blank part
   always_ff @(posedge clk_sys) begin
      if (por) begin
         persistent_setup_reg <= fcr_pkg::NV_RESET;
      end else if (wr_persist && !persist_bad) begin
         persistent_setup_reg <= persist_new;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (por) begin
         runtime_setup_reg <= fcr_pkg::V_RESET;
      end else if (rst) begin
         runtime_setup_reg <= {persistent_setup_reg[fcr_pkg::NV_DUMMY_LSB +: 4],
                               persistent_setup_reg[fcr_pkg::NV_XIP_LSB +: 3] == fcr_pkg::XIP_OFF,
                               1'b0, fcr_pkg::WRAP_NONE};
      end else if (wr_runtime) begin
         runtime_setup_reg <= runtime_new & ~(8'h01 << fcr_pkg::V_RSVD_BIT);
      end
   end

   // ****************************************
   // Working setup: never written directly
   // ****************************************
   // A runtime write keeps the power-on fields but can move xip_mode from off to fast read
   always_ff @(posedge clk_sys) begin
      if (por) begin
         cfg <= from_persist(fcr_pkg::NV_RESET);
         dummy_cycles <= dummy_count(fcr_pkg::NV_RESET[fcr_pkg::NV_DUMMY_LSB +: 4]);
      end else if (rst) begin
         cfg <= from_persist(persistent_setup_reg);
         dummy_cycles <= dummy_count(persistent_setup_reg[fcr_pkg::NV_DUMMY_LSB +: 4]);
      end else if (wr_runtime) begin
         cfg <= apply_runtime(cfg, runtime_new);
         dummy_cycles <= dummy_count(runtime_new[fcr_pkg::V_DUMMY_LSB +: 4]);
      end
   end

   // ****************************************
   // Read address sequencer
   // ****************************************
   logic [31:0] wrap_mask;

   always_comb begin
      case (cfg.wrap)
         fcr_pkg::WRAP_16: wrap_mask = fcr_pkg::MASK_16;
         fcr_pkg::WRAP_32: wrap_mask = fcr_pkg::MASK_32;
         fcr_pkg::WRAP_64: wrap_mask = fcr_pkg::MASK_64;
         default: wrap_mask = 32'hFFFF_FFFF;
      endcase
   end

   // Upper bits are kept, so a wrapping read never leaves its block
   always_ff @(posedge clk_sys) begin
      if (rst || por) begin
         rd_addr <= 32'h0000_0000;
      end else if (rd_load) begin
         rd_addr <= rd_load_addr;
      end else if (rd_step) begin
         rd_addr <= (rd_addr & ~wrap_mask) | ((rd_addr + 32'h0000_0001) & wrap_mask);
      end
   end

endmodule : fcr_config_regs

/* File: verif/fcr_config_regs_properties.sv */
`timescale 1ns/1ps
module fcr_config_regs_properties #(
   parameter logic [3:0] DUMMY_DEFAULT = 4'h8
) (
   // Clock and resets
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic por,
   // Watched outputs and inputs
   input wire logic link_cs_n,
   input wire logic link_miso_oe,
   input wire fcr_pkg::fcr_cfg_t cfg,
   input wire logic [3:0] dummy_cycles,
   input wire logic wr_enable_latch,
   input wire logic prot_err_set,
   input wire logic rd_load,
   input wire logic [31:0] rd_load_addr,
   input wire logic rd_step,
   input wire logic [31:0] rd_addr
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst || por);
   function automatic logic [31:0] nxt(logic [31:0] a, logic [1:0] w);
      logic [31:0] m;
      m = (w == 2'h3) ? 32'hFFFF_FFFF : (32'h0000_0010 << w) - 32'h0000_0001;
      return (a & ~m) | ((a + 32'h0000_0001) & m);
   endfunction : nxt
   sequence s_err_pulse;
      prot_err_set ##1 !prot_err_set;
   endsequence
   // Commands execute only after the frame closes
   sequence s_in_frame;
      !link_cs_n ##1 !link_cs_n;
   endsequence
   AST_CFG_HOLD: assert property (s_in_frame |-> $stable(cfg))
      else $error("working setup changed inside a frame");
   AST_POR: assert property (disable iff (1'b0)
      por |=> cfg.dummy_code == 4'hF && cfg.wrap == 2'h3 && cfg.xip_mode == 3'h7 && !cfg.dtr_en)
      else $error("power-on defaults missing");
   AST_RST: assert property (disable iff (1'b0)
      rst |=> !wr_enable_latch && !prot_err_set && rd_addr == 32'h0000_0000)
      else $error("reset state wrong");
   AST_ERR_PULSE: assert property (prot_err_set |-> s_err_pulse)
      else $error("error pulse too long");
   AST_ERR_LATCH: assert property (prot_err_set |-> ##[0:2] !wr_enable_latch)
      else $error("latch kept after refused write");
   AST_DUMMY: assert property (dummy_cycles == ((cfg.dummy_code == 4'h0 ||
      cfg.dummy_code == 4'hF) ? DUMMY_DEFAULT : cfg.dummy_code))
      else $error("dummy count decode wrong");
   AST_LOAD: assert property (rd_load |=> rd_addr == $past(rd_load_addr))
      else $error("start address not loaded");
   AST_STEP: assert property (rd_step && !rd_load |=>
      rd_addr == nxt($past(rd_addr), $past(cfg.wrap)))
      else $error("address step wrong");
   AST_IDLE_OE: assert property (link_cs_n |-> !link_miso_oe)
      else $error("data line driven outside frame");
endmodule : fcr_config_regs_properties
bind fcr_config_regs fcr_config_regs_properties #(.DUMMY_DEFAULT(DUMMY_DEFAULT)) u_props (
   .clk_sys(clk_sys), .rst(rst), .por(por), .link_cs_n(link_cs_n),
   .link_miso_oe(link_miso_oe), .cfg(cfg), .dummy_cycles(dummy_cycles),
   .wr_enable_latch(wr_enable_latch), .prot_err_set(prot_err_set), .rd_load(rd_load),
   .rd_load_addr(rd_load_addr), .rd_step(rd_step), .rd_addr(rd_addr));

/* File: verif/fcr_host_model.sv */
`timescale 1ns/1ps
module fcr_host_model (
   // Serial link
   output logic link_sclk,
   output logic link_cs_n,
   output logic link_mosi,
   input wire logic link_miso
);
   // ****************************************
   // Command frames, mode 0, 12 ns clock
   // ****************************************
   initial begin
      link_sclk = 1'b0;
      link_cs_n = 1'b1;
      link_mosi = 1'b0;
   end
   // Registers reached only by framed commands
   task automatic xfer(input logic [23:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      #3 link_cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         link_mosi = tx[i];
         #6 link_sclk = 1'b1;
         if (i < n - 8) rx = {rx[14:0], link_miso};
         #6 link_sclk = 1'b0;
      end
      #6 link_cs_n = 1'b1;
      // No pull on the line: leave no stale bit behind
      link_mosi = ~link_mosi;
   endtask : xfer
endmodule : fcr_host_model

/* File: verif/tb_flash_configuration_registers.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_flash_configuration_registers;
   localparam logic [3:0] DD = 4'h6;
   logic clk_sys, rst, por, link_sclk, link_cs_n, link_mosi, link_miso, link_miso_oe;
   logic wr_enable_latch, prot_err_set, rd_load, rd_step, latch;
   logic [3:0] dummy_cycles;
   logic [31:0] rd_load_addr, rd_addr;
   fcr_pkg::fcr_cfg_t cfg;
   int mismatches, checks_done, seed, err_seen, err_exp;
   logic [15:0] nv, nva, rx;
   logic [15:0] bad [3] = '{16'hFBFF, 16'hFDFF, 16'hFEBF};
   logic [3:0] codes [4] = '{4'h0, 4'h1, 4'hE, 4'hF};
   logic [7:0] vr, d;
   logic [2:0] xm;
   fcr_config_regs #(.DUMMY_DEFAULT(DD)) DUT (.clk_sys(clk_sys), .rst(rst), .por(por),
      .link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_mosi(link_mosi),
      .link_miso(link_miso), .link_miso_oe(link_miso_oe), .cfg(cfg),
      .dummy_cycles(dummy_cycles), .wr_enable_latch(wr_enable_latch),
      .prot_err_set(prot_err_set), .rd_load(rd_load), .rd_load_addr(rd_load_addr),
      .rd_step(rd_step), .rd_addr(rd_addr));
   fcr_host_model u_host (.link_sclk(link_sclk), .link_cs_n(link_cs_n),
      .link_mosi(link_mosi), .link_miso(link_miso));
   // ****************************************
   // Clock, model and tasks
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (prot_err_set === 1'b1) err_seen++;
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   task automatic cmd(input logic [23:0] tx, input int n);
      logic [7:0] op;
      logic [15:0] v;
      op = tx[n - 1 -: 8];
      v = {tx[7:0], tx[15:8]};
      u_host.xfer(tx, n, rx);
      if (op == 8'h06 && n == 8) latch = 1'b1;
      if (op == 8'h04 && n == 8) latch = 1'b0;
      if (op == 8'h81 && n == 16 && latch) begin
         vr = tx[7:0] & 8'hFB;
         // Enabling with no power-on mode falls back to plain fast read
         if (!tx[3] && xm == 3'h7) xm = 3'h0;
      end
      if (op == 8'hB1 && n == 24 && latch) begin
         if (v[11:9] inside {3'h5, 3'h6} || !v[6]) err_exp++;
         else nv = v;
         latch = 1'b0;
      end
      // Keeps the quiet gap between frames
      repeat (6) @(negedge clk_sys);
      `CHK(wr_enable_latch, latch);
      `CHK(err_seen, err_exp);
   endtask : cmd
   task automatic check_cfg();
      fcr_pkg::fcr_cfg_t e;
      e.dummy_code = vr[7:4];
      e.xip_en = ~vr[3];
      e.xip_mode = xm;
      e.drv = nva[8:6];
      e.dtr_en = ~nva[5];
      e.hold_rst_en = nva[4];
      e.proto = !nva[3] ? fcr_pkg::FCR_PROTO_QUAD :
         !nva[2] ? fcr_pkg::FCR_PROTO_DUAL : fcr_pkg::FCR_PROTO_EXT;
      e.seg_high = ~nva[1];
      e.four_byte = ~nva[0];
      e.wrap = vr[1:0];
      `CHK(cfg, e);
      `CHK(dummy_cycles, (vr[7:4] == 4'h0 || vr[7:4] == 4'hF) ? DD : vr[7:4]);
      cmd(24'h8500, 16);
      `CHK(rx[7:0], vr);
      cmd(24'hB5_0000, 24);
      `CHK({rx[7:0], rx[15:8]}, nv);
   endtask : check_cfg
   task automatic do_reset(input logic full);
      rst = 1'b1;
      por = full;
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      por = 1'b0;
      repeat (4) @(negedge clk_sys);
      if (full) nv = 16'hFFFF;
      nva = nv;
      xm = nv[11:9];
      vr = {nv[15:12], nv[11:9] == 3'h7, 1'b0, 2'h3};
      latch = 1'b0;
   endtask : do_reset
   task automatic seq_test(input logic [1:0] w);
      int a;
      cmd(24'h06, 8);
      cmd({16'h0081, 4'h5, 2'h2, w}, 16);
      check_cfg();
      a = $random(seed);
      rd_load_addr = a;
      rd_load = 1'b1;
      rd_step = 1'b1;
      @(negedge clk_sys);
      rd_load = 1'b0;
      `CHK(rd_addr, a);
      repeat (70) begin
         @(negedge clk_sys);
         a = (w == 2'h3) ? a + 1 : (a & ~((16 << w) - 1)) | ((a + 1) & ((16 << w) - 1));
         `CHK(rd_addr, a);
      end
      rd_step = 1'b0;
   endtask : seq_test
   initial begin
      #2_000_000;
      mismatches++;
      end_of_test();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      seed = 2;
      rd_load = 1'b0;
      rd_step = 1'b0;
      rd_load_addr = 32'h0000_0000;
      nv = 16'hFFFF;
      do_reset(1'b1);
      check_cfg();
      $display("test defaults finished");
      cmd(24'h8100, 16);
      cmd(24'h00C, 9);
      cmd(24'h06, 8);
      check_cfg();
      for (int i = 0; i < 6; i++) begin
         d = $random(seed);
         d[3:2] = {i != 5, 1'b0}; // Last pass enables execute-in-place
         if (i < 4) d[7:4] = codes[i];
         cmd({16'h0081, d}, 16);
         check_cfg();
      end
      $display("test runtime writes finished");
      foreach (bad[i]) begin
         cmd(24'h06, 8);
         cmd({8'hB1, bad[i][7:0], bad[i][15:8]}, 24);
      end
      cmd(24'h06, 8);
      cmd(24'hB1_C038, 24);
      check_cfg();
      do_reset(1'b0);
      check_cfg();
      cmd(24'h06, 8);
      cmd(24'h8112, 16);
      check_cfg();
      cmd(24'h06, 8);
      cmd(24'hB1_FB0F, 24);
      do_reset(1'b0);
      check_cfg();
      $display("test persistent setup finished");
      for (int w = 0; w < 4; w++) seq_test(w[1:0]);
      $display("test address wrap finished");
      do_reset(1'b1);
      check_cfg();
      $display("test power-on finished");
      end_of_test();
   end
endmodule : tb_flash_configuration_registers
